// >>> hdl/crac_pkg.sv
package crac_pkg;

    // operating modes
    localparam logic [1:0] MODE_REAL  = 2'h0;
    localparam logic [1:0] MODE_PROT  = 2'h1;
    localparam logic [1:0] MODE_V86   = 2'h2;

    // register classes
    typedef enum logic [3:0] {
        CLS_GENERAL  = 4'h0,
        CLS_SEGMENT  = 4'h1,
        CLS_FLAGS    = 4'h2,
        CLS_CONTROL  = 4'h3,
        CLS_GTABLE   = 4'h4,
        CLS_ITABLE   = 4'h5,
        CLS_LTABLE   = 4'h6,
        CLS_TASK     = 4'h7,
        CLS_FPU      = 4'h8,
        CLS_DEBUG    = 4'h9,
        CLS_TEST     = 4'hA
    } crac_class_e;

    // option word fields
    localparam int          OPT_MASK_LSB   = 0;
    localparam int          OPT_MASK_W     = 6;
    localparam int          OPT_PREC_LSB   = 8;
    localparam int          OPT_RND_LSB    = 10;
    localparam logic [15:0] OPT_RESET      = 16'h037F;
    localparam logic [15:0] OPT_DEFINED    = 16'h0F3F;

    // rounding_select encodings
    localparam logic [1:0] RND_NEAREST = 2'h0;
    localparam logic [1:0] RND_DOWN    = 2'h1;
    localparam logic [1:0] RND_UP      = 2'h2;
    localparam logic [1:0] RND_ZERO    = 2'h3;

    // precision_select encodings
    localparam logic [1:0] PREC_SINGLE = 2'h0;
    localparam logic [1:0] PREC_RSVD   = 2'h1;
    localparam logic [1:0] PREC_DOUBLE = 2'h2;
    localparam logic [1:0] PREC_EXT    = 2'h3;

    // significand widths
    localparam logic [6:0] SIG_SINGLE  = 7'h18;
    localparam logic [6:0] SIG_DOUBLE  = 7'h35;
    localparam logic [6:0] SIG_EXT     = 7'h40;

    // fpu operation kinds
    typedef enum logic [3:0] {
        FOP_ADD    = 4'h0,
        FOP_SUB    = 4'h1,
        FOP_MUL    = 4'h2,
        FOP_DIV    = 4'h3,
        FOP_SQRT   = 4'h4,
        FOP_STORE  = 4'h5,
        FOP_ISTORE = 4'h6,
        FOP_TRANS  = 4'h7,
        FOP_PREM   = 4'h8,
        FOP_XTRACT = 4'h9,
        FOP_ABS    = 4'hA,
        FOP_CHS    = 4'hB,
        FOP_OTHER  = 4'hC
    } crac_fop_e;

    // register indices inside debug and test groups
    localparam int DBG_REGS      = 8;
    localparam int DBG_BP_COUNT  = 4;
    localparam int DBG_RSVD_A    = 4;
    localparam int DBG_RSVD_B    = 5;
    localparam int DBG_STATE     = 6;
    localparam int DBG_SETUP     = 7;
    localparam int TST_FIRST     = 3;
    localparam int TST_REGS      = 5;

    localparam int QUEUE_BYTES   = 32;
    localparam int MAX_OPERANDS  = 3;

    typedef struct packed {
        logic        valid;
        logic        store;
        crac_class_e cls;
        logic [2:0]  index;
        logic [31:0] wdata;
    } crac_req_s;

    typedef struct packed {
        logic        done;
        logic        refused;
        logic [31:0] rdata;
    } crac_rsp_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] cpl;
        logic [1:0] io_privilege_level;
        logic       seg_big;
        logic       size_prefix;
    } crac_ctx_s;

endpackage

// >>> hdl/crac_core.sv
`timescale 1ns/100ps

// Behaviour
// RULE_01: six low option bits mask six exceptions
// RULE_02: unmasked exception sets flag, summary, error out
// RULE_03: rounding field in option bits ten, eleven
// RULE_04: rounding codes nearest, down, up, truncate
// RULE_05: rounding applies only to rounding operations
// RULE_06: precision field in bits eight, nine
// RULE_07: precision applies to add, sub, mul, div, sqrt
// RULE_08: four breakpoint addresses, setup and state registers
// RULE_09: software leaves reserved debug slots undefined
// RULE_10: five test registers for cache and lookaside
// RULE_11: protected mode privileged access needs level zero
// RULE_12: real and v86 mode refusals per table
// RULE_13: v86 flag push/pop checked against io level
// RULE_14: pointer image size from segment default flag; code lets the size prefix swap it too
// RULE_15: software writes zeros, masks reserved bits
// RULE_16: stored images reload without masking
// RULE_17: thirty-two byte prefetch queue depth
// RULE_18: default operand size, prefix swaps it
// RULE_19: zero to three operands, any location
module crac_core
    import crac_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire crac_req_s   req_i,
    input  wire crac_ctx_s   ctx_i,
    input  wire logic        flag_push_instr_i,
    input  wire logic        flag_pop_instr_i,
    input  wire logic        fpu_exc_valid_i,
    input  wire logic [5:0]  fpu_exc_i,
    input  wire crac_fop_e   fpu_op_i,
    input  wire logic [1:0]  operand_count_i,
    input  wire logic        prefetch_push_i,
    input  wire logic        prefetch_pop_i,
    input  wire logic        prefetch_flush_i,
    output crac_rsp_s        rsp_o,
    output logic             fpu_error_out_o,
    output logic [5:0]       fpu_exc_flags_o,
    output logic             error_summary_flag_o,
    output logic [1:0]       rounding_select_o,
    output logic             rounding_active_o,
    output logic [6:0]       precision_bits_o,
    output logic             operand_wide32_o,
    output logic             pointer_image32_o,
    output logic             flags_fault_o,
    output logic             operand_count_ok_o,
    output logic [5:0]       queue_level_o
);

    // privilege check by mode and class
    function automatic logic access_ok(input crac_class_e cls, input logic store,
                                       input crac_ctx_s ctx);
        logic ok;
        ok = 1'b0;
        case (ctx.mode)
            MODE_PROT: begin
                case (cls)
                    CLS_CONTROL, CLS_DEBUG, CLS_TEST: ok = (ctx.cpl == 2'h0); // RULE_11
                    CLS_GTABLE, CLS_ITABLE, CLS_LTABLE, CLS_TASK:
                        ok = store || (ctx.cpl == 2'h0); // RULE_11
                    default: ok = 1'b1;
                endcase
            end
            MODE_V86: begin
                case (cls)
                    CLS_CONTROL, CLS_GTABLE, CLS_ITABLE: ok = store; // RULE_12
                    CLS_LTABLE, CLS_TASK, CLS_DEBUG, CLS_TEST: ok = 1'b0; // RULE_12
                    CLS_FLAGS: ok = (ctx.cpl <= ctx.io_privilege_level); // RULE_13
                    default: ok = 1'b1; // RULE_12
                endcase
            end
            default: begin
                case (cls)
                    CLS_LTABLE, CLS_TASK: ok = 1'b0; // RULE_12
                    default: ok = 1'b1;
                endcase
            end
        endcase
        return ok;
    endfunction

    // significand width from precision code
    function automatic logic [6:0] sig_width(input logic [1:0] prec);
        logic [6:0] w;
        case (prec)
            PREC_SINGLE: w = SIG_SINGLE;
            PREC_DOUBLE: w = SIG_DOUBLE;
            default:     w = SIG_EXT;
        endcase
        return w;
    endfunction

    function automatic logic [5:0] unmasked(input logic [5:0] exc, input logic [15:0] opt);
        return exc & ~opt[OPT_MASK_LSB +: OPT_MASK_W];
    endfunction

    function automatic logic wide32(input crac_ctx_s ctx);
        return ctx.seg_big ^ ctx.size_prefix;
    endfunction

    function automatic logic [2:0] test_slot(input logic [2:0] index);
        return index - 3'(TST_FIRST);
    endfunction

    function automatic logic flag_fault(input crac_ctx_s ctx, input logic push,
                                        input logic pop);
        return (push || pop) && (ctx.mode == MODE_V86) && (ctx.io_privilege_level != 2'h3);
    endfunction

    function automatic logic [5:0] queue_next(input logic [5:0] lvl, input logic push,
                                              input logic pop, input logic flush);
        logic [5:0] nxt;
        nxt = lvl;
        if (flush) begin
            nxt = 6'h00;
        end else begin
            if (push && (lvl != 6'(QUEUE_BYTES))) nxt = nxt + 6'h01; // RULE_17
            if (pop && (lvl != 6'h00)) nxt = nxt - 6'h01;
        end
        return nxt;
    endfunction

    // architectural register state
    logic [15:0]          opt_q, opt_d;
    logic [5:0]           flags_q, flags_d;
    logic                 es_q, es_d;
    logic [31:0]          dbg_q [DBG_REGS];
    logic [31:0]          dbg_d [DBG_REGS];
    logic [31:0]          tst_q [TST_REGS];
    logic [31:0]          tst_d [TST_REGS];
    logic [31:0]          misc_q [4];
    logic [31:0]          misc_d [4];

    // access response
    crac_rsp_s            rsp_q, rsp_d;

    // fpu operation controls
    logic [1:0]           rnd_q, rnd_d;
    logic                 ract_q, ract_d;
    logic [6:0]           prec_q, prec_d;

    // context and operand count derived outputs
    logic                 w32_q, w32_d;
    logic                 p32_q, p32_d;
    logic                 ffault_q, ffault_d;
    logic                 opok_q, opok_d;

    // prefetch queue fill
    logic [5:0]           qlvl_q, qlvl_d;

    // register loads and stores
    always_comb begin
        logic        ok;
        logic [31:0] rd;
        ok      = 1'b0;
        rd      = 32'h0000_0000;
        opt_d   = opt_q;
        dbg_d   = dbg_q;
        tst_d   = tst_q;
        misc_d  = misc_q;
        rsp_d   = '0;
        if (req_i.valid) begin
            ok = access_ok(req_i.cls, req_i.store, ctx_i);
            rsp_d.done    = 1'b1;
            rsp_d.refused = !ok;
            if (ok) begin
                case (req_i.cls)
                    CLS_FPU: begin
                        if (req_i.store) rd = {16'h0000, opt_q};
                        else opt_d = req_i.wdata[15:0]; // RULE_16
                    end
                    CLS_DEBUG: begin
                        if (req_i.store) rd = dbg_q[req_i.index]; // RULE_08
                        else dbg_d[req_i.index] = req_i.wdata; // RULE_08
                    end
                    CLS_TEST: begin
                        if (req_i.index >= 3'(TST_FIRST)) begin // RULE_10
                            if (req_i.store) rd = tst_q[test_slot(req_i.index)];
                            else tst_d[test_slot(req_i.index)] = req_i.wdata;
                        end
                    end
                    CLS_GTABLE, CLS_ITABLE, CLS_LTABLE, CLS_TASK: begin
                        if (req_i.store) rd = misc_q[req_i.cls[1:0]];
                        else misc_d[req_i.cls[1:0]] = req_i.wdata;
                    end
                    default: rd = 32'h0000_0000;
                endcase
            end
            rsp_d.rdata = rd;
        end
    end

    // sticky exception flags and summary
    always_comb begin
        logic [5:0] unm;
        unm     = unmasked(fpu_exc_i, opt_q); // RULE_01
        flags_d = flags_q;
        if (fpu_exc_valid_i) flags_d = flags_q | fpu_exc_i;
        if (fpu_exc_valid_i && (unm != 6'h00)) flags_d = flags_d | unm; // RULE_02
        es_d    = |unmasked(flags_d, opt_d); // RULE_02
    end

    // rounding and precision selection
    always_comb begin
        rnd_d = opt_q[OPT_RND_LSB +: 2]; // RULE_03 RULE_04
        case (fpu_op_i)
            FOP_PREM, FOP_XTRACT, FOP_ABS, FOP_CHS, FOP_OTHER: ract_d = 1'b0; // RULE_05
            default: ract_d = 1'b1; // RULE_05
        endcase
        case (fpu_op_i)
            FOP_ADD, FOP_SUB, FOP_MUL, FOP_DIV, FOP_SQRT:
                prec_d = sig_width(opt_q[OPT_PREC_LSB +: 2]); // RULE_06 RULE_07
            default: prec_d = SIG_EXT; // RULE_07
        endcase
    end

    // operand size, flag faults, operand count
    always_comb begin
        w32_d    = wide32(ctx_i); // RULE_18
        p32_d    = wide32(ctx_i); // RULE_14
        ffault_d = flag_fault(ctx_i, flag_push_instr_i, flag_pop_instr_i); // RULE_13
        opok_d   = (32'(operand_count_i) <= MAX_OPERANDS); // RULE_19
    end

    // prefetch queue fill level
    always_comb begin
        qlvl_d = queue_next(qlvl_q, prefetch_push_i, prefetch_pop_i, prefetch_flush_i);
    end

    // register file and response
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            opt_q    <= OPT_RESET;
            flags_q  <= 6'h00;
            es_q     <= 1'b0;
            dbg_q    <= '{default: 32'h0000_0000};
            tst_q    <= '{default: 32'h0000_0000};
            misc_q   <= '{default: 32'h0000_0000};
            rsp_q    <= '0;
        end else begin
            opt_q    <= opt_d;
            flags_q  <= flags_d;
            es_q     <= es_d;
            dbg_q    <= dbg_d;
            tst_q    <= tst_d;
            misc_q   <= misc_d;
            rsp_q    <= rsp_d;
        end
    end

    // fpu operation controls
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rnd_q    <= RND_NEAREST;
            ract_q   <= 1'b0;
            prec_q   <= SIG_EXT;
        end else begin
            rnd_q    <= rnd_d;
            ract_q   <= ract_d;
            prec_q   <= prec_d;
        end
    end

    // context and operand count derived outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w32_q    <= 1'b0;
            p32_q    <= 1'b0;
            ffault_q <= 1'b0;
            opok_q   <= 1'b1;
        end else begin
            w32_q    <= w32_d;
            p32_q    <= p32_d;
            ffault_q <= ffault_d;
            opok_q   <= opok_d;
        end
    end

    // prefetch queue fill
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            qlvl_q   <= 6'h00;
        end else begin
            qlvl_q   <= qlvl_d;
        end
    end

    // top outputs straight from flops
    assign rsp_o                = rsp_q;
    assign fpu_error_out_o      = es_q; // RULE_02
    assign fpu_exc_flags_o      = flags_q;
    assign error_summary_flag_o = es_q;
    assign rounding_select_o    = rnd_q;
    assign rounding_active_o    = ract_q;
    assign precision_bits_o     = prec_q;
    assign operand_wide32_o     = w32_q;
    assign pointer_image32_o    = p32_q;
    assign flags_fault_o        = ffault_q;
    assign operand_count_ok_o   = opok_q;
    assign queue_level_o        = qlvl_q;

endmodule

// >>> testbench/crac_assertions.sv
`timescale 1ns/100ps
module crac_assertions
    import crac_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire crac_req_s  req_i,
    input wire crac_ctx_s  ctx_i,
    input wire logic       flag_push_instr_i,
    input wire logic       fpu_exc_valid_i,
    input wire logic [5:0] fpu_exc_i,
    input wire crac_fop_e  fpu_op_i,
    input wire logic       prefetch_flush_i,
    input wire crac_rsp_s  rsp_o,
    input wire logic       fpu_error_out_o,
    input wire logic [5:0] fpu_exc_flags_o,
    input wire logic       error_summary_flag_o,
    input wire logic [6:0] precision_bits_o,
    input wire logic       operand_wide32_o,
    input wire logic       pointer_image32_o,
    input wire logic       flags_fault_o,
    input wire logic [5:0] queue_level_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_ref;
        rsp_o.done && rsp_o.refused && rsp_o.rdata == 32'h0000_0000;
    endsequence
    sequence s_ok;
        rsp_o.done && !rsp_o.refused;
    endsequence
    property p_done;
        req_i.valid |=> rsp_o.done;
    endproperty
    a_done: assert property (p_done) else $error("no done after request");
    property p_prot;
        req_i.valid && ctx_i.mode == MODE_PROT && ctx_i.cpl != 2'h0
            && req_i.cls inside {CLS_CONTROL, CLS_DEBUG, CLS_TEST} |=> s_ref;
    endproperty
    a_prot: assert property (p_prot) else $error("privileged access granted");
    property p_real;
        req_i.valid && ctx_i.mode == MODE_REAL && req_i.cls inside {CLS_LTABLE, CLS_TASK}
            |=> s_ref;
    endproperty
    a_real: assert property (p_real) else $error("real mode selector access granted");
    property p_v86;
        req_i.valid && ctx_i.mode == MODE_V86 && (req_i.cls inside {CLS_DEBUG, CLS_TEST,
            CLS_LTABLE, CLS_TASK} || (!req_i.store && req_i.cls inside {CLS_CONTROL,
            CLS_GTABLE, CLS_ITABLE})) |=> s_ref;
    endproperty
    a_v86: assert property (p_v86) else $error("v86 access granted");
    property p_open;
        req_i.valid && req_i.cls inside {CLS_GENERAL, CLS_SEGMENT, CLS_FPU} |=> s_ok;
    endproperty
    a_open: assert property (p_open) else $error("open class refused");
    property p_fault;
        flag_push_instr_i && ctx_i.mode == MODE_V86 && ctx_i.io_privilege_level != 2'h3 |=> flags_fault_o;
    endproperty
    a_fault: assert property (p_fault) else $error("flag push not faulted");
    property p_exc;
        fpu_exc_valid_i |=> (fpu_exc_flags_o & $past(fpu_exc_i)) == $past(fpu_exc_i);
    endproperty
    a_exc: assert property (p_exc) else $error("exception flag not set");
    property p_fpu_error_out;
        fpu_error_out_o == error_summary_flag_o
            && (!fpu_error_out_o || fpu_exc_flags_o != 6'h00);
    endproperty
    a_fpu_error_out: assert property (p_fpu_error_out) else $error("error out differs from summary");
    property p_prec;
        !(fpu_op_i inside {FOP_ADD, FOP_SUB, FOP_MUL, FOP_DIV, FOP_SQRT})
            |=> precision_bits_o == SIG_EXT;
    endproperty
    a_prec: assert property (p_prec) else $error("precision not extended");
    property p_size;
        1'b1 |=> operand_wide32_o == ($past(ctx_i.seg_big) ^ $past(ctx_i.size_prefix))
            && pointer_image32_o == operand_wide32_o;
    endproperty
    a_size: assert property (p_size) else $error("operand size wrong");
    property p_flush;
        prefetch_flush_i |=> queue_level_o == 6'h00 ##1 queue_level_o <= 6'h01;
    endproperty
    a_flush: assert property (p_flush) else $error("queue not flushed");
endmodule

bind crac_core crac_assertions chk_u (.clk_i, .sys_rst_i, .req_i, .ctx_i, .flag_push_instr_i,
    .fpu_exc_valid_i, .fpu_exc_i, .fpu_op_i, .prefetch_flush_i, .rsp_o, .fpu_error_out_o,
    .fpu_exc_flags_o, .error_summary_flag_o, .precision_bits_o, .operand_wide32_o,
    .pointer_image32_o, .flags_fault_o, .queue_level_o);

// >>> testbench/crac_core_tb.sv
`timescale 1ns/100ps
module crac_core_tb
    import crac_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    crac_req_s   req_i = '0;
    crac_ctx_s   ctx_i = '0;
    logic        flag_push_instr_i = 1'b0;
    logic        flag_pop_instr_i = 1'b0;
    logic        fpu_exc_valid_i = 1'b0;
    logic [5:0]  fpu_exc_i = 6'h00;
    crac_fop_e   fpu_op_i = FOP_OTHER;
    logic [1:0]  operand_count_i = 2'h0;
    logic        prefetch_push_i = 1'b0;
    logic        prefetch_pop_i = 1'b0;
    logic        prefetch_flush_i = 1'b0;
    crac_rsp_s   rsp_o;
    logic [5:0]  fpu_exc_flags_o, queue_level_o;
    logic [6:0]  precision_bits_o;
    logic [1:0]  rounding_select_o;
    logic        fpu_error_out_o, error_summary_flag_o, rounding_active_o, operand_wide32_o;
    logic        pointer_image32_o, flags_fault_o, operand_count_ok_o;
    logic [31:0] rd;
    int          n_fail = 0, compares = 0, cycles = 0;

    crac_core dut_u (.clk_i, .sys_rst_i, .req_i, .ctx_i, .flag_push_instr_i, .flag_pop_instr_i,
        .fpu_exc_valid_i, .fpu_exc_i, .fpu_op_i, .operand_count_i, .prefetch_push_i,
        .prefetch_pop_i, .prefetch_flush_i, .rsp_o, .fpu_error_out_o, .fpu_exc_flags_o,
        .error_summary_flag_o, .rounding_select_o, .rounding_active_o, .precision_bits_o,
        .operand_wide32_o, .pointer_image32_o, .flags_fault_o, .operand_count_ok_o,
        .queue_level_o);

    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 2000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic acc(input logic st, input crac_class_e c, input logic [2:0] ix,
                       input logic [31:0] wd, input logic rf);
        @(negedge clk_i);
        req_i = '{1'b1, st, c, ix, wd};
        tick();
        req_i.valid = 1'b0;
        rd = rsp_o.rdata;
        check(rsp_o.done, 1'b1);
        check(rsp_o.refused, rf);
        if (rf) check(rd, 32'h0000_0000);
    endtask
    task automatic ld(input logic [15:0] w);
        acc(1'b0, CLS_FPU, 3'h0, {16'h0000, w}, 1'b0);
        tick();
    endtask
    task automatic row(input logic [1:0] m, c, io, input logic st, input crac_class_e cl,
                       input logic rf);
        ctx_i.mode = m;
        ctx_i.cpl = c;
        ctx_i.io_privilege_level = io;
        acc(st, cl, 3'h1, 32'h0000_0000, rf);
    endtask
    task automatic exc(input logic [5:0] e);
        fpu_exc_i = e;
        fpu_exc_valid_i = 1'b1;
        tick();
        fpu_exc_valid_i = 1'b0;
    endtask
    task automatic t_fpu();
        logic [15:0] img;
        ctx_i.mode = MODE_PROT;
        acc(1'b1, CLS_FPU, 3'h0, 32'h0000_0000, 1'b0);
        img = rd[15:0];
        check(rd, {16'h0000, OPT_RESET});
        check(precision_bits_o, SIG_EXT);
        exc(6'h08);
        check(fpu_exc_flags_o, 6'h08);
        check(error_summary_flag_o, 1'b0);
        ld(16'h003E);
        check(error_summary_flag_o, 1'b0);
        exc(6'h01);
        check(fpu_exc_flags_o, 6'h09);
        check(fpu_error_out_o, 1'b1);
        ld(16'h0C3F);
        check(error_summary_flag_o, 1'b0);
        acc(1'b1, CLS_FPU, 3'h0, 32'h0000_0000, 1'b0);
        check(rd & {16'h0000, OPT_DEFINED}, 32'h0000_0C3F);
        ld(img);
        acc(1'b1, CLS_FPU, 3'h0, 32'h0000_0000, 1'b0);
        check(rd, {16'h0000, OPT_RESET});
    endtask
    task automatic t_fields();
        logic [1:0] k;
        for (int i = 3; i >= 0; i--) begin
            k = 2'(i);
            ld({4'h0, k, k, 8'h3F});
            fpu_op_i = FOP_DIV;
            tick();
            check(rounding_select_o, k);
            check(precision_bits_o, k == PREC_SINGLE ? SIG_SINGLE :
                  k == PREC_DOUBLE ? SIG_DOUBLE : SIG_EXT);
        end
        for (int i = 0; i < 13; i++) begin
            fpu_op_i = crac_fop_e'(i);
            tick();
            check(precision_bits_o, i < 5 ? SIG_SINGLE : SIG_EXT);
            check(rounding_active_o, i < 8);
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            if (i != DBG_RSVD_A && i != DBG_RSVD_B)
                acc(1'b0, CLS_DEBUG, 3'(i), 32'hA5A5_0000 + i, 1'b0);
            acc(1'b0, CLS_TEST, 3'(i), 32'h5A5A_0000 + i, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            if (i != DBG_RSVD_A && i != DBG_RSVD_B) begin
                acc(1'b1, CLS_DEBUG, 3'(i), 32'h0000_0000, 1'b0);
                check(rd, 32'hA5A5_0000 + i);
            end
            acc(1'b1, CLS_TEST, 3'(i), 32'h0000_0000, 1'b0);
            check(rd, i >= TST_FIRST ? 32'h5A5A_0000 + i : 32'h0000_0000);
        end
        row(MODE_PROT, 2'h1, 2'h0, 1'b0, CLS_DEBUG, 1'b1);
        row(MODE_PROT, 2'h0, 2'h0, 1'b1, CLS_DEBUG, 1'b0);
        check(rd, 32'hA5A5_0001);
    endtask
    task automatic t_table();
        row(MODE_PROT, 2'h1, 2'h0, 1'b0, CLS_CONTROL, 1'b1);
        row(MODE_PROT, 2'h3, 2'h0, 1'b1, CLS_TEST, 1'b1);
        row(MODE_PROT, 2'h2, 2'h0, 1'b1, CLS_GTABLE, 1'b0);
        row(MODE_PROT, 2'h2, 2'h0, 1'b0, CLS_ITABLE, 1'b1);
        row(MODE_PROT, 2'h0, 2'h0, 1'b0, CLS_LTABLE, 1'b0);
        row(MODE_REAL, 2'h3, 2'h0, 1'b0, CLS_LTABLE, 1'b1);
        row(MODE_REAL, 2'h0, 2'h0, 1'b1, CLS_TASK, 1'b1);
        row(MODE_REAL, 2'h3, 2'h0, 1'b0, CLS_DEBUG, 1'b0);
        row(MODE_V86, 2'h3, 2'h3, 1'b0, CLS_CONTROL, 1'b1);
        row(MODE_V86, 2'h3, 2'h3, 1'b1, CLS_CONTROL, 1'b0);
        row(MODE_V86, 2'h3, 2'h3, 1'b1, CLS_ITABLE, 1'b0);
        row(MODE_V86, 2'h3, 2'h3, 1'b0, CLS_GTABLE, 1'b1);
        row(MODE_V86, 2'h0, 2'h3, 1'b1, CLS_DEBUG, 1'b1);
        row(MODE_V86, 2'h0, 2'h3, 1'b0, CLS_TEST, 1'b1);
        row(MODE_V86, 2'h0, 2'h3, 1'b1, CLS_TASK, 1'b1);
        row(MODE_V86, 2'h3, 2'h0, 1'b0, CLS_FLAGS, 1'b1);
        row(MODE_V86, 2'h3, 2'h3, 1'b1, CLS_FLAGS, 1'b0);
        row(MODE_V86, 2'h3, 2'h0, 1'b0, CLS_GENERAL, 1'b0);
        row(MODE_V86, 2'h3, 2'h0, 1'b1, CLS_SEGMENT, 1'b0);
        row(MODE_V86, 2'h3, 2'h0, 1'b1, CLS_FPU, 1'b0);
    endtask
    task automatic t_misc();
        ctx_i.io_privilege_level = 2'h2;
        flag_push_instr_i = 1'b1;
        tick();
        check(flags_fault_o, 1'b1);
        ctx_i.io_privilege_level = 2'h3;
        tick();
        check(flags_fault_o, 1'b0);
        flag_push_instr_i = 1'b0;
        flag_pop_instr_i = 1'b1;
        ctx_i.io_privilege_level = 2'h1;
        tick();
        check(flags_fault_o, 1'b1);
        flag_pop_instr_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {ctx_i.seg_big, ctx_i.size_prefix} = 2'(i);
            operand_count_i = 2'(i);
            tick();
            check(operand_wide32_o, i == 1 || i == 2);
            check(pointer_image32_o, i == 1 || i == 2);
            check(operand_count_ok_o, 1'b1);
        end
    endtask
    task automatic t_queue();
        prefetch_push_i = 1'b1;
        repeat (33) tick();
        prefetch_push_i = 1'b0;
        check(queue_level_o, 6'h20);
        prefetch_pop_i = 1'b1;
        tick();
        prefetch_pop_i = 1'b0;
        check(queue_level_o, 6'h1F);
        prefetch_flush_i = 1'b1;
        tick();
        prefetch_flush_i = 1'b0;
        check(queue_level_o, 6'h00);
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_fpu();
        t_fields();
        t_regs();
        t_table();
        t_misc();
        t_queue();
        finish_test();
    end
endmodule
